// ### hw/srf_rx_full.sv
`timescale 1ns/100ps

// Two-flop synchroniser; only the second stage is read outside.
module srf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Data.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // First stage, read only by the second.

  // Both stages reset to the pins' idle level, so that no false select
  // or false edge is seen in the cycles right after reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : srf_sync

module srf_rx_full
  import srf_pkg::*;
(
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST_B,
  // Register port.
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [BYTE_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [BYTE_W-1:0] RDATA,
  // Serial link pins, asynchronous to CLOCK.
  input wire logic SCK_IN,
  input wire logic MOSI_IN,
  input wire logic SS_B_IN,
  // DMA handshake.
  input wire logic RX_DMA_DONE,
  output logic RX_DMA_REQ,
  // Interrupt.
  output logic IRQ
);

  srf_link_s link_raw; // Raw pins gathered.
  srf_link_s link_s; // Pins after two flops.
  assign link_raw = '{sck: SCK_IN, mosi: MOSI_IN, ss_b: SS_B_IN};

  srf_sync #(.W($bits(srf_link_s)), .RST_VAL(LINK_IDLE)) u_sync (
    .clk(CLOCK),
    .rst_b(RST_B),
    .d(link_raw),
    .q(link_s)
  );

  // Receiver state.
  srf_rx_e rx_q, rx_d;
  logic sck_prev_q, sck_prev_d; // Last sampled clock level.
  logic [PTR_W-1:0] bit_q, bit_d; // Bit counter within a byte.
  logic [BYTE_W-1:0] shift_q, shift_d; // Shifter.
  logic push; // Completed byte this cycle.
  logic [BYTE_W-1:0] push_byte; // The completed byte.

  // Mode 0 slave: sample data on each rising link clock edge while
  // selected. Deselect abandons a partial byte.
  always_comb begin
    rx_d = rx_q;
    sck_prev_d = link_s.sck;
    bit_d = bit_q;
    shift_d = shift_q;
    push = 1'b0;
    push_byte = {shift_q[BYTE_W-2:0], link_s.mosi};
    case (rx_q)
      RX_IDLE: begin
        bit_d = PTR_ZERO;
        if (!link_s.ss_b) begin
          rx_d = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (link_s.ss_b) begin
          rx_d = RX_IDLE;
          bit_d = PTR_ZERO;
        end else if (link_s.sck && !sck_prev_q) begin
          shift_d = push_byte;
          bit_d = bit_q + PTR_ONE;
          push = (bit_q == BIT_LAST);
        end
      end
      default: begin
        rx_d = RX_IDLE;
      end
    endcase
  end

  // Receiver registers.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rx_q <= RX_IDLE;
      sck_prev_q <= 1'b0;
      bit_q <= PTR_ZERO;
      shift_q <= RST_BYTE;
    end else begin
      rx_q <= rx_d;
      sck_prev_q <= sck_prev_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
    end
  end

  // Software state.
  srf_ctrl_s ctrl_q, ctrl_d; // Mode bits.
  logic [BYTE_W-1:0] mlo_q, mlo_d; // Match value, low byte.
  logic [BYTE_W-1:0] mhi_q, mhi_d; // Match value, high byte.
  logic [INT_W-1:0] ist_q, ist_d; // Sticky interrupt status.
  logic [INT_W-1:0] imask_q, imask_d; // Interrupt mask.
  logic [BYTE_W-1:0] rdata_q, rdata_d; // Read data, one cycle late.
  logic irq_q, irq_d; // Registered interrupt.
  logic dreq_q, dreq_d; // Registered DMA request.

  // Receive storage and flags.
  logic [BYTE_W-1:0] mem_q [FIFO_DEPTH];
  logic [BYTE_W-1:0] mem_d [FIFO_DEPTH];
  logic [PTR_W-1:0] wp_q, wp_d; // Write pointer.
  logic [PTR_W-1:0] rp_q, rp_d; // Read pointer.
  logic [CNT_W-1:0] cnt_q, cnt_d; // Bytes held.
  logic full_q, full_d; // Receive full flag.
  logic match_q, match_d; // Receive match flag.
  logic full_arm_q, full_arm_d; // Status read while full seen.
  logic match_arm_q, match_arm_d; // Status read while match seen.
  logic [CNT_W-1:0] cap; // One byte buffered, eight in FIFO mode.
  logic rd_stat, rd_data, wr_stat; // Decoded accesses.
  logic pop, push_ok, mode_chg;

  assign cap = ctrl_q.fifo_mode ? CNT_FULL : CNT_ONE;
  assign rd_stat = RD && (ADDR == OFS_STATUS);
  assign rd_data = RD && (ADDR == OFS_DATA_LO);
  assign wr_stat = WR && (ADDR == OFS_STATUS);
  assign mode_chg = WR && (ADDR == OFS_CTRL) &&
                    (WDATA[CTRL_FIFO_BIT] != ctrl_q.fifo_mode);

  // Storage, flags, registers and interrupt. A pop and a push in the
  // same cycle leave the count, so an arriving byte keeps the flag up.
  always_comb begin
    ctrl_d = ctrl_q;
    mlo_d = mlo_q;
    mhi_d = mhi_q;
    imask_d = imask_q;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    full_arm_d = full_arm_q;
    match_arm_d = match_arm_q;
    match_d = match_q;
    ist_d = ist_q;
    rdata_d = RST_BYTE;
    // Without DMA, buffered mode pops only after the status read and FIFO
    // mode on any data read; with DMA on, only DMA done pops, one byte.
    if (ctrl_q.dma_en) begin
      pop = RX_DMA_DONE && (cnt_q != CNT_ZERO);
    end else if (ctrl_q.fifo_mode) begin
      pop = rd_data && (cnt_q != CNT_ZERO);
    end else begin
      pop = rd_data && full_arm_q && (cnt_q != CNT_ZERO);
    end
    // An overrun byte is dropped when no room is left.
    push_ok = push && ((cnt_q < cap) || pop);
    if (pop) begin
      rp_d = rp_q + PTR_ONE;
    end
    if (push_ok) begin
      mem_d[wp_q] = push_byte;
      wp_d = wp_q + PTR_ONE;
    end
    cnt_d = cnt_q + {3'h0, push_ok} - {3'h0, pop};
    if (rd_data) begin
      full_arm_d = 1'b0;
    end
    if (rd_stat && full_q) begin
      full_arm_d = 1'b1;
    end
    // Write-one to the match bit clears it once armed by a read.
    if (wr_stat && match_arm_q && WDATA[STAT_MATCH_BIT]) begin
      match_d = 1'b0;
      match_arm_d = 1'b0;
    end
    if (rd_stat && match_q) begin
      match_arm_d = 1'b1;
    end
    if (push_ok && (push_byte == mlo_q)) begin
      match_d = 1'b1;
    end
    // Register writes.
    if (WR) begin
      case (ADDR)
        OFS_CTRL: begin
          ctrl_d.fifo_mode = WDATA[CTRL_FIFO_BIT];
          ctrl_d.dma_en = WDATA[CTRL_DMA_BIT];
        end
        OFS_MATCH_LO: mlo_d = WDATA;
        OFS_MATCH_HI: mhi_d = WDATA;
        OFS_INT_STAT: ist_d = ist_q & ~WDATA[INT_W-1:0];
        OFS_INT_MASK: imask_d = WDATA[INT_W-1:0];
        default: begin
        end
      endcase
    end
    // A mode change empties the storage, as the buffer sizes differ.
    if (mode_chg) begin
      wp_d = PTR_ZERO;
      rp_d = PTR_ZERO;
      cnt_d = CNT_ZERO;
      full_arm_d = 1'b0;
    end
    // Flag follows the fill level: any byte when buffered, eight in
    // FIFO mode.
    if (ctrl_d.fifo_mode) begin
      full_d = (cnt_d == CNT_FULL);
    end else begin
      full_d = (cnt_d != CNT_ZERO);
    end
    // Events set sticky bits after the clear, so the set wins.
    if (full_d && !full_q) begin
      ist_d[INT_FULL_BIT] = 1'b1;
    end
    if (match_d && !match_q) begin
      ist_d[INT_MATCH_BIT] = 1'b1;
    end
    irq_d = |(ist_d & imask_d);
    dreq_d = ctrl_d.dma_en && full_d;
    // Read data.
    if (RD) begin
      case (ADDR)
        OFS_STATUS: begin
          rdata_d[STAT_FULL_BIT] = full_q;
          rdata_d[STAT_MATCH_BIT] = match_q;
        end
        OFS_CTRL: begin
          rdata_d[CTRL_FIFO_BIT] = ctrl_q.fifo_mode;
          rdata_d[CTRL_DMA_BIT] = ctrl_q.dma_en;
        end
        OFS_MATCH_LO: rdata_d = mlo_q;
        OFS_MATCH_HI: rdata_d = mhi_q;
        OFS_DATA_LO: rdata_d = mem_q[rp_q];
        OFS_INT_STAT: rdata_d[INT_W-1:0] = ist_q;
        OFS_INT_MASK: rdata_d[INT_W-1:0] = imask_q;
        default: rdata_d = RST_BYTE;
      endcase
    end
  end

  // Storage, flag and register flip-flops.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= '0;
      mlo_q <= RST_BYTE;
      mhi_q <= RST_BYTE;
      imask_q <= RST_INT;
      ist_q <= RST_INT;
      mem_q <= '{default: RST_BYTE};
      wp_q <= PTR_ZERO;
      rp_q <= PTR_ZERO;
      cnt_q <= CNT_ZERO;
      full_q <= 1'b0;
      match_q <= 1'b0;
      full_arm_q <= 1'b0;
      match_arm_q <= 1'b0;
      rdata_q <= RST_BYTE;
      irq_q <= 1'b0;
      dreq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      mlo_q <= mlo_d;
      mhi_q <= mhi_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      match_q <= match_d;
      full_arm_q <= full_arm_d;
      match_arm_q <= match_arm_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      dreq_q <= dreq_d;
    end
  end

  assign RDATA = rdata_q;
  assign IRQ = irq_q;
  assign RX_DMA_REQ = dreq_q;

  // Checks on the flag logic.
  property p_buf_dma_clr;
    @(posedge CLOCK) disable iff (!RST_B)
    (!ctrl_q.fifo_mode && ctrl_q.dma_en && RX_DMA_DONE && full_q &&
     !push && !WR) |=> !full_q;
  endproperty
  a_buf_dma_clr: assert property (p_buf_dma_clr)
    else $error("Buffered DMA done did not clear full flag.");

  property p_fifo_set;
    @(posedge CLOCK) disable iff (!RST_B)
    (ctrl_q.fifo_mode && cnt_q == (CNT_FULL - CNT_ONE) && push && !pop &&
     !WR)
    |=> full_q && cnt_q == CNT_FULL;
  endproperty
  a_fifo_set: assert property (p_fifo_set)
    else $error("Eighth byte did not set full flag.");

  property p_fifo_rd_clr;
    @(posedge CLOCK) disable iff (!RST_B)
    (ctrl_q.fifo_mode && !ctrl_q.dma_en && rd_data && full_q && !push)
    |=> !full_q ##1 (!full_q || $past(push));
  endproperty
  a_fifo_rd_clr: assert property (p_fifo_rd_clr)
    else $error("FIFO data read did not clear full flag.");

  property p_fifo_dma_clr;
    @(posedge CLOCK) disable iff (!RST_B)
    (ctrl_q.fifo_mode && ctrl_q.dma_en && RX_DMA_DONE && full_q &&
     !push && !WR) |=> !full_q && !RX_DMA_REQ;
  endproperty
  a_fifo_dma_clr: assert property (p_fifo_dma_clr)
    else $error("First FIFO DMA done did not clear full flag.");

  property p_flag_read;
    @(posedge CLOCK) disable iff (!RST_B)
    rd_stat |=> RDATA[STAT_FULL_BIT] == $past(full_q);
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("Status read shows wrong full flag.");

  property p_buf_set;
    @(posedge CLOCK) disable iff (!RST_B)
    (!ctrl_q.fifo_mode && push_ok && !mode_chg) |=> full_q;
  endproperty
  a_buf_set: assert property (p_buf_set)
    else $error("Received byte did not set full flag.");

  property p_buf_no_arm;
    @(posedge CLOCK) disable iff (!RST_B)
    (!ctrl_q.fifo_mode && !ctrl_q.dma_en && rd_data && !full_arm_q &&
     full_q && !WR) |=> full_q;
  endproperty
  a_buf_no_arm: assert property (p_buf_no_arm)
    else $error("Data read without status read cleared flag.");

  property p_match_set;
    @(posedge CLOCK) disable iff (!RST_B)
    (push_ok && push_byte == mlo_q) |=> match_q;
  endproperty
  a_match_set: assert property (p_match_set)
    else $error("Matching byte did not set match flag.");

  // Unmasking a pending event must raise the line at the next edge; the
  // status clear sits at another address, so nothing can cancel it.
  property p_irq;
    @(posedge CLOCK) disable iff (!RST_B)
    (WR && ADDR == OFS_INT_MASK && |(ist_q & WDATA[INT_W-1:0])) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt output disagrees with status and mask.");

  c_fifo_full: cover property (@(posedge CLOCK) disable iff (!RST_B)
    ctrl_q.fifo_mode && full_q);
  c_dma_clr: cover property (@(posedge CLOCK) disable iff (!RST_B)
    ctrl_q.dma_en && RX_DMA_DONE && full_q);
  c_match: cover property (@(posedge CLOCK) disable iff (!RST_B)
    $rose(match_q));

endmodule : srf_rx_full

// ### hw/srf_pkg.sv
package srf_pkg;

  // Register bus widths; data is one byte per register.
  localparam int ADDR_W = 4;
  localparam int BYTE_W = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_MATCH_LO = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MATCH_HI = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_DATA_LO = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_DATA_HI = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 4'h9;

  // Field positions.
  localparam int STAT_FULL_BIT = 7;
  localparam int STAT_MATCH_BIT = 6;
  localparam int CTRL_FIFO_BIT = 0;
  localparam int CTRL_DMA_BIT = 1;
  localparam int INT_FULL_BIT = 0;
  localparam int INT_MATCH_BIT = 1;
  localparam int INT_W = 2;

  // Reset values.
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
  localparam logic [INT_W-1:0] RST_INT = 2'h0;

  // Receive storage: eight bytes make the 64-bit FIFO.
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
  localparam logic [PTR_W-1:0] PTR_ZERO = 3'h0;
  localparam logic [PTR_W-1:0] BIT_LAST = 3'h7;

  // Receiver states, one-hot.
  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_SHIFT = 2'b10
  } srf_rx_e;

  // Mode bits that software sets.
  typedef struct packed {
    logic dma_en;
    logic fifo_mode;
  } srf_ctrl_s;

  // Synchronised link pins.
  typedef struct packed {
    logic sck;
    logic mosi;
    logic ss_b;
  } srf_link_s;

  // Idle level of the link pins: clock low, select released.
  localparam srf_link_s LINK_IDLE = '{sck: 1'b0, mosi: 1'b0, ss_b: 1'b1};

endpackage : srf_pkg

// ### sim/srf_dma_model.sv
`timescale 1ns/100ps

// Stand-in for the DMA engine that drains received bytes on request.
module srf_dma_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Handshake with the block.
  input wire logic req,
  output logic done,
  // Bench control.
  input wire logic go,
  input wire logic [3:0] delay,
  output logic [7:0] count
);
  logic [3:0] wait_q; // Cycles spent waiting on this request.
  logic busy_q; // A pulse was sent; wait for the request to fall.

  // One done pulse per request, after the set delay. The model then waits
  // for the request to drop, so a flag that never clears is not re-served.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 4'h0;
      busy_q <= 1'b0;
      done <= 1'b0;
      count <= 8'h00;
    end else begin
      done <= 1'b0;
      if (!req) begin
        wait_q <= 4'h0;
        busy_q <= 1'b0;
      end else if (go && !busy_q) begin
        if (wait_q == delay) begin
          done <= 1'b1;
          busy_q <= 1'b1;
          count <= count + 8'h01;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule : srf_dma_model

// ### sim/srf_rx_full_test.sv
`timescale 1ns/100ps

// Self-checking bench for the receive-full flag block.
module srf_rx_full_test;
  import srf_pkg::*;
  logic clock, rst_b, wr, rd, sck, mosi, ss_b, go;
  logic [ADDR_W-1:0] addr;
  logic [BYTE_W-1:0] wdata, rdata, v;
  logic dma_done, dma_req, irq;
  logic [7:0] dma_cnt;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  srf_rx_full dut (.CLOCK(clock), .RST_B(rst_b), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SCK_IN(sck),
    .MOSI_IN(mosi), .SS_B_IN(ss_b), .RX_DMA_DONE(dma_done),
    .RX_DMA_REQ(dma_req), .IRQ(irq));
  srf_dma_model dma (.clk(clock), .rst_b(rst_b), .req(dma_req),
    .done(dma_done), .go(go), .delay(4'h5), .count(dma_cnt));

  // Free-running clock, 4 ns period.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Hang guard; the whole run needs well under a third of this.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Single-cycle write strobe.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic chk_stat(input logic [7:0] exp);
    rd_reg(OFS_STATUS, v);
    chk("status", exp, v);
  endtask : chk_stat

  // One mode-0 frame, MSB first, 48 ns link period; lines let go after.
  task automatic send_byte(input logic [7:0] b);
    @(posedge clock);
    ss_b <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi <= b[i];
      repeat (6) @(posedge clock);
      sck <= 1'b1;
      repeat (6) @(posedge clock);
      sck <= 1'b0;
    end
    repeat (6) @(posedge clock);
    ss_b <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge clock);
  endtask : send_byte

  task automatic t_reset();
    chk_stat(8'h00);
    rd_reg(4'ha, v);
    chk("unmapped", 8'h00, v);
    rd_reg(OFS_DATA_HI, v);
    chk("data high", 8'h00, v);
    chk("req", 8'h00, {7'h0, dma_req});
  endtask : t_reset

  // A data read without the status read first must not clear the flag.
  task automatic t_buffered();
    send_byte(8'ha5);
    rd_reg(OFS_DATA_LO, v);
    chk("data", 8'ha5, v);
    chk_stat(8'h80);
    rd_reg(OFS_DATA_LO, v);
    chk_stat(8'h00);
  endtask : t_buffered

  task automatic t_irq();
    rd_reg(OFS_INT_STAT, v);
    chk("int status", 8'h01, v);
    chk("irq masked", 8'h00, {7'h0, irq});
    wr_reg(OFS_INT_MASK, 8'h01);
    @(posedge clock);
    #1 chk("irq", 8'h01, {7'h0, irq});
    wr_reg(OFS_INT_STAT, 8'h01);
    @(posedge clock);
    #1 chk("irq cleared", 8'h00, {7'h0, irq});
    rd_reg(OFS_INT_MASK, v);
    chk("int mask", 8'h01, v);
    wr_reg(OFS_INT_MASK, 8'h00);
  endtask : t_irq

  // Seven bytes leave the FIFO short of full; the eighth fills it.
  task automatic t_fifo();
    wr_reg(OFS_CTRL, 8'h01);
    for (int k = 1; k < 8; k++) begin
      send_byte(8'h11 * k[7:0]);
    end
    chk_stat(8'h00);
    send_byte(8'h88);
    chk_stat(8'h80);
    rd_reg(OFS_DATA_LO, v);
    chk("fifo data", 8'h11, v);
    chk_stat(8'h00);
  endtask : t_fifo

  // Let the DMA stand-in serve; the request is looked at on the falling
  // edge, where it has settled, and go changes only on a rising edge.
  task automatic wait_drop();
    @(posedge clock);
    go <= 1'b1;
    for (int n = 0; n < 40 && dma_req; n++) begin
      @(negedge clock);
    end
    @(posedge clock);
    go <= 1'b0;
  endtask : wait_drop

  task automatic t_dma(input logic [7:0] mode, input int nbytes);
    wr_reg(OFS_CTRL, mode);
    rd_reg(OFS_CTRL, v);
    chk("ctrl", mode, v);
    for (int k = 0; k < nbytes; k++) begin
      send_byte(8'h5a + k[7:0]);
    end
    chk("req", 8'h01, {7'h0, dma_req});
    chk_stat(8'h80);
    wait_drop();
    chk_stat(8'h00);
  endtask : t_dma

  task automatic t_match();
    wr_reg(OFS_CTRL, 8'h00);
    wr_reg(OFS_MATCH_LO, 8'h3c);
    send_byte(8'h3c);
    chk_stat(8'hc0);
    wr_reg(OFS_STATUS, 8'h40);
    chk_stat(8'h80);
    wr_reg(OFS_MATCH_HI, 8'hc3);
    rd_reg(OFS_MATCH_HI, v);
    chk("match high", 8'hc3, v);
    rd_reg(OFS_MATCH_LO, v);
    chk("match low", 8'h3c, v);
  endtask : t_match

  initial begin
    rst_b = 1'b0;
    {wr, rd, sck, go} = 4'h0;
    {ss_b, mosi} = 2'b11;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset();
    t_buffered();
    t_irq();
    t_fifo();
    t_dma(8'h02, 1);
    t_dma(8'h03, 8);
    chk("dma pulses", 8'h02, dma_cnt);
    t_match();
    give_verdict();
  end
endmodule : srf_rx_full_test
